/* File: rtl/edo_dram_cycle_control.sv */
`timescale 1ns/10ps
module edo_dram_cycle_control
    import edo_ctrl_pkg::*;
#(
    parameter int STARTUP_COUNT = STARTUP_CYC,
    parameter int REFRESH_COUNT = REF_INTERVAL_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    input wire logic [1:0] req_op,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic init_done,
    output logic test_active,
    // memory pins, strobes active low
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic oe_n,
    output logic [ROW_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_pins_i,
    output logic [DATA_W-1:0] data_pins_o,
    output logic data_pins_oe
);
    // ==========================================================
    // sequencer states
    typedef enum logic [3:0] {
        S_POWER = 4'b0000,
        S_IDLE = 4'b0001,
        S_ROW = 4'b0010,
        S_COL = 4'b0011,
        S_SAMPLE = 4'b0100,
        S_WLATE = 4'b0101,
        S_END = 4'b0110,
        S_PRE = 4'b0111,
        S_REF_CAS = 4'b1000,
        S_REF_RAS = 4'b1001,
        S_REF_END = 4'b1010,
        S_TEST_GO = 4'b1011
    } state_e;

    state_e state;
    logic [$clog2(STARTUP_COUNT+1)-1:0] start_cnt;
    logic [$clog2(REFRESH_COUNT+1)-1:0] ref_cnt;
    logic ref_due;
    logic [3:0] init_cnt;
    logic [1:0] wait_cnt;
    op_e op;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] wdata;
    logic enter_test;

    // ==========================================================
    // refresh interval timer; a pending refresh wins over requests not yet granted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_cnt <= '0;
            ref_due <= 1'b0;
        end else begin
            if (ref_cnt == ($bits(ref_cnt))'(REFRESH_COUNT - 1)) begin
                ref_cnt <= '0;
                ref_due <= 1'b1;
            end else begin
                ref_cnt <= ref_cnt + 1'b1;
                if (state == S_REF_END) begin
                    ref_due <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // main sequencer, one strobe phase per 100 ns cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= S_POWER;
            start_cnt <= '0;
            init_cnt <= '0;
            init_done <= 1'b0;
            test_active <= 1'b0;
            enter_test <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            addr <= '0;
            data_pins_o <= 8'h00;
            data_pins_oe <= 1'b0;
            wait_cnt <= '0;
            op <= OP_READ;
            col <= '0;
            wdata <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            case (state)
                S_POWER: begin
                    // strobes held high during the start-up delay
                    if (start_cnt == ($bits(start_cnt))'(STARTUP_COUNT - 1)) begin
                        state <= S_REF_CAS;
                    end else begin
                        start_cnt <= start_cnt + 1'b1;
                    end
                end
                S_IDLE: begin
                    // a granted request is taken before a due refresh, never dropped
                    if (req_valid && req_ready) begin
                        op <= op_e'(req_op);
                        col <= req_col;
                        wdata <= req_wdata;
                        addr <= req_row;
                        ras_n <= 1'b0;
                        state <= S_ROW;
                        if (op_e'(req_op) == OP_TEST && !test_active) begin
                            // test read needs mode entry first
                            enter_test <= 1'b1;
                            ras_n <= 1'b1;
                            state <= S_REF_CAS;
                        end
                    end else if (ref_due || (test_active && req_valid
                            && op_e'(req_op) != OP_TEST)) begin
                        enter_test <= 1'b0;
                        state <= S_REF_CAS;
                    end else if (req_valid) begin
                        req_ready <= 1'b1;
                    end
                end
                S_TEST_GO: begin
                    // one cycle of row precharge after the entry refresh
                    ras_n <= 1'b0;
                    state <= S_ROW;
                end
                S_ROW: begin
                    addr <= ROW_W'(col);
                    if (op == OP_TEST) begin
                        addr[COL_TEST_BIT] <= 1'b0;
                    end
                    cas_n <= 1'b0;
                    if (op == OP_WRITE) begin
                        we_n <= 1'b0;
                        data_pins_o <= wdata;
                        data_pins_oe <= 1'b1;
                    end else begin
                        oe_n <= 1'b0;
                    end
                    wait_cnt <= (op == OP_TEST) ? 2'(EXTRA_CYC) : 2'b00;
                    state <= S_COL;
                end
                S_COL: begin
                    if (wait_cnt != 2'b00) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end else begin
                        state <= S_SAMPLE;
                    end
                end
                S_SAMPLE: begin
                    if (op == OP_WRITE) begin
                        state <= S_END;
                    end else begin
                        rsp_rdata <= data_pins_i;
                        rsp_valid <= 1'b1;
                        if (op == OP_RMW) begin
                            // late write: output off, then drive data
                            oe_n <= 1'b1;
                            data_pins_o <= wdata;
                            state <= S_WLATE;
                        end else begin
                            state <= S_END;
                        end
                    end
                end
                S_WLATE: begin
                    data_pins_oe <= 1'b1;
                    we_n <= 1'b0;
                    state <= S_END;
                end
                S_END: begin
                    // write strobe kept high in reads until strobes rise
                    cas_n <= 1'b1;
                    ras_n <= 1'b1;
                    oe_n <= 1'b1;
                    state <= S_PRE;
                end
                S_PRE: begin
                    we_n <= 1'b1;
                    data_pins_oe <= 1'b0;
                    state <= S_IDLE;
                end
                S_REF_CAS: begin
                    cas_n <= 1'b0;
                    we_n <= ~enter_test;
                    state <= S_REF_RAS;
                end
                S_REF_RAS: begin
                    ras_n <= 1'b0;
                    test_active <= enter_test;
                    state <= S_REF_END;
                end
                S_REF_END: begin
                    ras_n <= 1'b1;
                    cas_n <= 1'b1;
                    we_n <= 1'b1;
                    enter_test <= 1'b0;
                    if (!init_done) begin
                        init_cnt <= init_cnt + 1'b1;
                        if (init_cnt == 4'(INIT_CYCLES - 1)) begin
                            init_done <= 1'b1;
                        end
                    end
                    // entry refresh goes on to the pending test read
                    state <= enter_test ? S_TEST_GO
                        : ((init_done || init_cnt == 4'(INIT_CYCLES - 1)) ? S_IDLE
                        : S_REF_CAS);
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // checks
    a_init_before_use: assert property (@(posedge sys_clk) disable iff (rst)
        (state == S_ROW) |-> init_done)
        else $error("access before init");
    a_early_write_pins: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(cas_n) && state == S_COL && op == OP_WRITE |-> !we_n && data_pins_oe)
        else $error("early write not set up");
    a_read_we_high: assert property (@(posedge sys_clk) disable iff (rst)
        state inside {S_COL, S_SAMPLE, S_END} && (op == OP_READ || op == OP_TEST)
        |-> we_n)
        else $error("we low in read");
    a_strobes_release: assert property (@(posedge sys_clk) disable iff (rst)
        state == S_END |=> ras_n && cas_n)
        else $error("strobes not released together");
    a_test_entry: assert property (@(posedge sys_clk) disable iff (rst)
        state == S_REF_RAS && enter_test |=> test_active)
        else $error("test entry missed");
    a_test_exit: assert property (@(posedge sys_clk) disable iff (rst)
        state == S_REF_RAS && !enter_test |=> !test_active)
        else $error("test exit missed");
    a_rmw_order: assert property (@(posedge sys_clk) disable iff (rst)
        state == S_SAMPLE && op == OP_RMW |=> we_n ##1 !we_n)
        else $error("rmw write not late");
    a_no_test_normal: assert property (@(posedge sys_clk) disable iff (rst)
        state == S_ROW && op != OP_TEST |-> !test_active)
        else $error("normal access in test mode");
    c_write: cover property (@(posedge sys_clk) state == S_SAMPLE && op == OP_WRITE);
    c_rmw: cover property (@(posedge sys_clk) state == S_WLATE);
    c_test_read: cover property (@(posedge sys_clk) rsp_valid && test_active);
    c_refresh: cover property (@(posedge sys_clk) init_done && state == S_REF_RAS);
endmodule

/* File: rtl/edo_ctrl_pkg.sv */
package edo_ctrl_pkg;
    localparam int CLK_MHZ = 10;
    localparam int STARTUP_US = 200;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int INIT_CYCLES = 8;
    localparam int ROWS = 2048;
    localparam int REF_PERIOD_MS = 32;
    localparam int REF_INTERVAL_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / ROWS;
    localparam int TEST_EXTRA_NS = 5;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int EXTRA_CYC = (TEST_EXTRA_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_W = 11;
    localparam int COL_W = 10;
    localparam int COL_TEST_BIT = 9;
    localparam int DATA_W = 8;
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_RMW = 2'b10,
        OP_TEST = 2'b11
    } op_e;
endpackage

/* File: dv/edo_dram_model.sv */
`timescale 1ns/10ps
module edo_dram_model
    import edo_ctrl_pkg::*;
(
    // strobes and address
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [ROW_W-1:0] addr,
    // data wire
    input wire logic [DATA_W-1:0] din,
    input wire logic din_oe,
    output logic [DATA_W-1:0] bus
);
    // ==========
    // cell array and mode
    // only three row bits kept; the scenarios touch few rows
    localparam logic [COL_W-1:0] PAIR_BIT = COL_W'(1) << COL_TEST_BIT;
    logic [DATA_W-1:0] mem [0:8191];
    logic [ROW_W-1:0] row = '0;
    logic [COL_W-1:0] col = '0;
    logic test = 1'b0;
    logic drv = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] q = '0;
    logic [DATA_W-1:0] last = '0;
    // strobes, address and data change on one edge; let them settle first
    always @(negedge ras_n) begin
        #1;
        if (!cas_n) test = !we_n;
        else row = addr;
    end
    always @(negedge cas_n) begin
        #1;
        if (!ras_n) begin
            col = addr[COL_W-1:0];
            if (test) col[COL_TEST_BIT] = 1'b0;
            rd = we_n;
            if (!we_n) mem[{row[2:0], col}] = din;
            else begin
                q = mem[{row[2:0], col}];
                if (test) q = ~(q ^ mem[{row[2:0], col | PAIR_BIT}]);
                drv = 1'b1;
            end
        end
    end
    always @(negedge we_n) if (!cas_n && !ras_n && rd) begin
        mem[{row[2:0], col}] = din;
    end
    // output stays on until both strobes are high
    always @(posedge ras_n or posedge cas_n) if (ras_n && cas_n) drv = 1'b0;
    // released wire shows inverse of last level so stale data never matches
    always @(din, din_oe, q, drv, oe_n) begin
        if (din_oe) last = din;
        else if (drv && !oe_n) last = q;
    end
    assign bus = din_oe ? din : (drv && !oe_n) ? q : ~last;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb
    import edo_ctrl_pkg::*;
;
    localparam int STARTUP_TB = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [ROW_W-1:0] req_row = '0;
    logic [COL_W-1:0] req_col = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, init_done, test_active;
    logic ras_n, cas_n, we_n, oe_n, data_pins_oe;
    logic [DATA_W-1:0] rsp_rdata, data_pins_i, data_pins_o, rd;
    logic [ROW_W-1:0] addr;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int refs = 0;
    int first_ref = 0;
    int base;
    edo_dram_cycle_control #(.STARTUP_COUNT(STARTUP_TB), .REFRESH_COUNT(40)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
        .test_active(test_active), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
        .addr(addr), .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
        .data_pins_oe(data_pins_oe));
    edo_dram_model i_mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
        .din(data_pins_o), .din_oe(data_pins_oe), .bus(data_pins_i));
    // ==========
    // clock, timeout, refresh counting
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    always @(negedge ras_n) if (!cas_n) begin
        if (refs == 0) first_ref = cyc;
        refs++;
    end
    // ==========
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic access(input logic [1:0] op, input logic [ROW_W-1:0] r,
                          input logic [COL_W-1:0] c, input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        // keeps a new request off the edge where the last one dropped valid
        @(negedge sys_clk);
        req_op = op;
        req_row = r;
        req_col = c;
        req_wdata = wd;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (op != OP_WRITE && rsp_valid !== 1'b1 && n < 320) begin
            @(negedge sys_clk);
            n++;
        end
        rd = rsp_rdata;
        check(n < 300, 1);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic test_init();
        while (init_done !== 1'b1 && cyc < 500) @(negedge sys_clk);
        check(refs, 8);
        check(first_ref >= STARTUP_TB + 3, 1);
        $display("test_init done");
    endtask
    task automatic test_write_read();
        access(OP_WRITE, 11'h005, 10'h003, 8'hA5);
        access(OP_READ, 11'h005, 10'h003, 8'h00);
        check(rd, 8'hA5);
        $display("test_write_read done");
    endtask
    task automatic test_rmw();
        access(OP_RMW, 11'h005, 10'h003, 8'h3C);
        check(rd, 8'hA5);
        access(OP_READ, 11'h005, 10'h003, 8'h00);
        check(rd, 8'h3C);
        $display("test_rmw done");
    endtask
    task automatic test_mode();
        access(OP_WRITE, 11'h007, 10'h010, 8'h66);
        access(OP_WRITE, 11'h007, 10'h210, 8'h66);
        access(OP_TEST, 11'h007, 10'h210, 8'h00);
        check(rd, 8'hFF);
        check(test_active, 1'b1);
        access(OP_WRITE, 11'h007, 10'h010, 8'h0F);
        access(OP_TEST, 11'h007, 10'h010, 8'h00);
        check(rd, 8'h96);
        access(OP_READ, 11'h007, 10'h210, 8'h00);
        check(rd, 8'h66);
        check(test_active, 1'b0);
        $display("test_mode done");
    endtask
    task automatic test_refresh();
        base = refs;
        repeat (100) @(negedge sys_clk);
        check(refs - base >= 2, 1);
        $display("test_refresh done");
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        test_init();
        test_write_read();
        test_rmw();
        test_mode();
        test_refresh();
        test_done();
    end
endmodule
